/* File: logic/strap_config_defs.svh */
// Constants for the strap configuration latch.
// Functional notes
// - High reference select enables internal reference.
// - Straps sampled at full reset release, held.
// - Reset low duration separates full from partial.
// - Reset held low keeps device in shutdown.
// - Hardware mode: sequencer follows its strap.
// - Range select 00 means software mode.
// - Hardware range: 01 2.5V, 10 5V, 11 10V.
// - Mode latched at full reset; range tracked live.
// - Interface select low parallel, high serial.
// - Single-lane select low: lane A only.
// - Parallel data pins are three-state when idle.
// - Hardware serial: oversampling latched from upper pins.
// - Hardware mode: burst enable latched at release.
`ifndef STRAP_CONFIG_DEFS_SVH
`define STRAP_CONFIG_DEFS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define PARTIAL_RESET_MIN_NS 50
`define FULL_RESET_MIN_NS 1000
`define PARTIAL_RESET_CYCLES \
    ((`PARTIAL_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULL_RESET_CYCLES \
    ((`FULL_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W 8

// ==========================================================
// Pin fields
`define DATA_W 16
`define SINGLE_LANE_BIT 4
`define OS_HI_BIT 15
`define OS_LO_BIT 13
`define OS_W 3

// ==========================================================
// Range codes
`define RANGE_SOFTWARE 2'h0
`define RANGE_2V5 2'h1
`define RANGE_5V 2'h2
`define RANGE_10V 2'h3

`endif

/* File: logic/strap_config_pkg.sv */
// Types for the strap configuration latch.
`include "strap_config_defs.svh"

package strap_config_pkg;

    typedef logic [`RST_CNT_W-1:0] rst_cnt_t;

    typedef struct packed {
        rst_cnt_t cnt;
        logic pin_prev;
        logic full_p;
        logic partial_p;
        logic shutdown;
    } classify_s;

    typedef struct packed {
        logic valid;
        logic ref_internal;
        logic seq_strap;
        logic serial_if;
        logic single_lane_hi;
        logic software_mode;
        logic [`OS_W-1:0] oversampling;
        logic burst;
        logic [1:0] range;
        logic full_p;
        logic partial_p;
        logic shutdown;
        logic [`DATA_W-1:0] db_out;
        logic [`DATA_W-1:0] db_oe_n;
        logic lane_a;
        logic lane_b;
        logic lane_a_oe_n;
        logic lane_b_oe_n;
    } loader_s;

endpackage

/* File: logic/reset_class_if.sv */
// Reset classification events between classifier and loader.
`timescale 1ns/1ps

interface reset_class_if;
    logic full_release;
    logic partial_release;
    logic shutdown;

    modport classifier (
        output full_release,
        output partial_release,
        output shutdown
    );

    modport loader (
        input full_release,
        input partial_release,
        input shutdown
    );
endinterface

/* File: logic/reset_pulse_classifier.sv */
// Measures the reset pin low time and classifies the pulse.
`timescale 1ns/1ps
`include "strap_config_defs.svh"

module reset_pulse_classifier (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    reset_class_if.classifier ev
);
    localparam strap_config_pkg::rst_cnt_t FULL_CNT =
        `RST_CNT_W'(`FULL_RESET_CYCLES);
    localparam strap_config_pkg::rst_cnt_t PART_CNT =
        `RST_CNT_W'(`PARTIAL_RESET_CYCLES);

    strap_config_pkg::classify_s st_ff;
    strap_config_pkg::classify_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pin_prev = reset_pin_n;
        nxt_st.full_p = 1'b0;
        nxt_st.partial_p = 1'b0;
        if (!reset_pin_n) begin
            // Saturate so a very long hold never wraps into a short one.
            if (st_ff.cnt != FULL_CNT) begin
                nxt_st.cnt = st_ff.cnt + `RST_CNT_W'(1);
            end
            nxt_st.shutdown = 1'b1;
        end else begin
            nxt_st.cnt = '0;
            nxt_st.shutdown = 1'b0;
            if (!st_ff.pin_prev) begin
                nxt_st.full_p = (st_ff.cnt >= FULL_CNT);
                nxt_st.partial_p = (st_ff.cnt >= PART_CNT) &&
                    (st_ff.cnt < FULL_CNT);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{cnt: '0, pin_prev: 1'b1, full_p: 1'b0,
                partial_p: 1'b0, shutdown: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ev.full_release = st_ff.full_p;
    assign ev.partial_release = st_ff.partial_p;
    assign ev.shutdown = st_ff.shutdown;
endmodule

/* File: logic/strap_config_latch.sv */
// Strap configuration latch with reset decode and pin drivers.
`timescale 1ns/1ps
`include "strap_config_defs.svh"

module strap_config_latch (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic RESET_PIN_N,
    input wire logic REFERENCE_SOURCE_SELECT,
    input wire logic SEQUENCER_ENABLE_STRAP,
    input wire logic RANGE_MODE_SELECT_HI,
    input wire logic RANGE_MODE_SELECT_LO,
    input wire logic INTERFACE_TYPE_SELECT,
    input wire logic BURST_STRAP,
    input wire logic [`DATA_W-1:0] PARALLEL_DATA_IN,
    input wire logic [`DATA_W-1:0] CORE_PARALLEL_DATA,
    input wire logic CORE_PARALLEL_DRIVE,
    input wire logic CORE_SERIAL_BIT_A,
    input wire logic CORE_SERIAL_BIT_B,
    input wire logic CORE_SERIAL_DRIVE,
    output logic CONFIG_VALID,
    output logic INTERNAL_REFERENCE_EN,
    output logic SEQUENCER_EN,
    output logic SOFTWARE_MODE,
    output logic [1:0] INPUT_RANGE,
    output logic SERIAL_INTERFACE,
    output logic DUAL_LANE_EN,
    output logic [`OS_W-1:0] OVERSAMPLING,
    output logic BURST_EN,
    output logic FULL_RESET_PULSE,
    output logic PARTIAL_RESET_PULSE,
    output logic SHUTDOWN,
    output logic [`DATA_W-1:0] PARALLEL_DATA_OUT,
    output logic [`DATA_W-1:0] PARALLEL_DATA_OE_N,
    output logic SERIAL_OUT_LANE_A,
    output logic SERIAL_OUT_LANE_A_OE_N,
    output logic SERIAL_OUT_LANE_B,
    output logic SERIAL_OUT_LANE_B_OE_N
);
    reset_class_if ev ();

    reset_pulse_classifier u_classifier (
        .clk(CORE_CLK),
        .rst(RST),
        .reset_pin_n(RESET_PIN_N),
        .ev(ev.classifier)
    );

    strap_config_pkg::loader_s st_ff;
    strap_config_pkg::loader_s nxt_st;
    logic [1:0] range_pins;
    logic hw_mode;

    assign range_pins = {RANGE_MODE_SELECT_HI, RANGE_MODE_SELECT_LO};
    assign hw_mode = !st_ff.software_mode;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.full_p = ev.full_release;
        nxt_st.partial_p = ev.partial_release;
        nxt_st.shutdown = ev.shutdown;
        // ==========================================================
        // Capture all straps on one edge; partial reset keeps them.
        if (ev.full_release) begin
            nxt_st.valid = 1'b1;
            nxt_st.ref_internal = REFERENCE_SOURCE_SELECT;
            nxt_st.seq_strap = SEQUENCER_ENABLE_STRAP;
            nxt_st.serial_if = INTERFACE_TYPE_SELECT;
            nxt_st.single_lane_hi =
                PARALLEL_DATA_IN[`SINGLE_LANE_BIT];
            nxt_st.software_mode =
                (range_pins == `RANGE_SOFTWARE);
            nxt_st.oversampling =
                PARALLEL_DATA_IN[`OS_HI_BIT:`OS_LO_BIT];
            nxt_st.burst = BURST_STRAP;
        end
        // ==========================================================
        // Range follows the pins live while in hardware mode.
        if (st_ff.valid && hw_mode) begin
            nxt_st.range = range_pins;
        end else begin
            nxt_st.range = `RANGE_SOFTWARE;
        end
        // ==========================================================
        // Pin drivers; nothing drives while in shutdown.
        nxt_st.db_out = CORE_PARALLEL_DATA;
        if (st_ff.valid && !st_ff.serial_if && CORE_PARALLEL_DRIVE &&
            !ev.shutdown) begin
            nxt_st.db_oe_n = '0;
        end else begin
            nxt_st.db_oe_n = '1;
        end
        nxt_st.lane_a = CORE_SERIAL_BIT_A;
        nxt_st.lane_b = CORE_SERIAL_BIT_B;
        nxt_st.lane_a_oe_n = !(st_ff.valid && st_ff.serial_if &&
            CORE_SERIAL_DRIVE && !ev.shutdown);
        nxt_st.lane_b_oe_n = !(st_ff.valid && st_ff.serial_if &&
            st_ff.single_lane_hi && CORE_SERIAL_DRIVE &&
            !ev.shutdown);
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_ff <= '{valid: 1'b0, ref_internal: 1'b0, seq_strap: 1'b0,
                serial_if: 1'b0, single_lane_hi: 1'b0,
                software_mode: 1'b1, oversampling: '0, burst: 1'b0,
                range: `RANGE_SOFTWARE, full_p: 1'b0, partial_p: 1'b0,
                shutdown: 1'b0, db_out: '0, db_oe_n: '1, lane_a: 1'b0,
                lane_b: 1'b0, lane_a_oe_n: 1'b1, lane_b_oe_n: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Decoded views of the stored straps, straight from the flops.
    // Oversampling and burst are only meaningful in hardware mode,
    // so software mode shows them as zero rather than stale pins.
    logic ref_en_ff;
    logic seq_en_ff;
    logic dual_ff;
    logic [`OS_W-1:0] os_ff;
    logic burst_ff;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ref_en_ff <= 1'b0;
            seq_en_ff <= 1'b0;
            dual_ff <= 1'b0;
            os_ff <= '0;
            burst_ff <= 1'b0;
        end else begin
            ref_en_ff <= nxt_st.valid && nxt_st.ref_internal;
            seq_en_ff <= nxt_st.valid && !nxt_st.software_mode &&
                nxt_st.seq_strap;
            dual_ff <= nxt_st.valid && nxt_st.serial_if &&
                nxt_st.single_lane_hi;
            os_ff <= (nxt_st.valid && !nxt_st.software_mode &&
                nxt_st.serial_if) ? nxt_st.oversampling : '0;
            burst_ff <= nxt_st.valid && !nxt_st.software_mode &&
                nxt_st.burst;
        end
    end

    assign CONFIG_VALID = st_ff.valid;
    assign INTERNAL_REFERENCE_EN = ref_en_ff;
    assign SEQUENCER_EN = seq_en_ff;
    assign SOFTWARE_MODE = st_ff.software_mode;
    assign INPUT_RANGE = st_ff.range;
    assign SERIAL_INTERFACE = st_ff.serial_if;
    assign DUAL_LANE_EN = dual_ff;
    assign OVERSAMPLING = os_ff;
    assign BURST_EN = burst_ff;
    assign FULL_RESET_PULSE = st_ff.full_p;
    assign PARTIAL_RESET_PULSE = st_ff.partial_p;
    assign SHUTDOWN = st_ff.shutdown;
    assign PARALLEL_DATA_OUT = st_ff.db_out;
    assign PARALLEL_DATA_OE_N = st_ff.db_oe_n;
    assign SERIAL_OUT_LANE_A = st_ff.lane_a;
    assign SERIAL_OUT_LANE_A_OE_N = st_ff.lane_a_oe_n;
    assign SERIAL_OUT_LANE_B = st_ff.lane_b;
    assign SERIAL_OUT_LANE_B_OE_N = st_ff.lane_b_oe_n;
endmodule

/* File: tb/strap_config_latch_properties.sv */
// Port checks for the strap configuration latch.
`timescale 1ns/1ps
`include "strap_config_defs.svh"
module strap_config_latch_properties (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic RESET_PIN_N,
    input wire logic RANGE_MODE_SELECT_HI,
    input wire logic RANGE_MODE_SELECT_LO,
    input wire logic INTERNAL_REFERENCE_EN,
    input wire logic SEQUENCER_EN,
    input wire logic SOFTWARE_MODE,
    input wire logic [1:0] INPUT_RANGE,
    input wire logic SERIAL_INTERFACE,
    input wire logic DUAL_LANE_EN,
    input wire logic [`OS_W-1:0] OVERSAMPLING,
    input wire logic BURST_EN,
    input wire logic FULL_RESET_PULSE,
    input wire logic PARTIAL_RESET_PULSE,
    input wire logic SHUTDOWN,
    input wire logic [`DATA_W-1:0] PARALLEL_DATA_OE_N,
    input wire logic SERIAL_OUT_LANE_B_OE_N
);
    logic [7:0] low_ff;
    logic [7:0] run_ff;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    // ==========================================================
    // Low pulse length
    // Saturates so a held pin never wraps into the partial band.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            low_ff <= 8'h00;
            run_ff <= 8'h00;
        end else if (!RESET_PIN_N) begin
            low_ff <= (low_ff == 8'hff) ? low_ff : low_ff + 8'h01;
        end else if (low_ff != 8'h00) begin
            run_ff <= low_ff;
            low_ff <= 8'h00;
        end
    end
    // ==========================================================
    // Assertions
    chk_full_len: assert property (
        FULL_RESET_PULSE |-> run_ff >= 8'h64)
        else $error("full pulse after short low");
    chk_part_len: assert property (
        PARTIAL_RESET_PULSE |-> run_ff >= 8'h05 && run_ff <= 8'h63)
        else $error("partial pulse out of band");
    chk_pulse_one: assert property (
        FULL_RESET_PULSE || PARTIAL_RESET_PULSE |=> !FULL_RESET_PULSE
        && !PARTIAL_RESET_PULSE) else $error("reset pulse too long");
    chk_shut_on: assert property (
        !RESET_PIN_N [*3] |=> SHUTDOWN) else $error("no shutdown");
    chk_shut_off: assert property (
        RESET_PIN_N [*4] |=> !SHUTDOWN) else $error("shutdown stuck");
    chk_latch_hold: assert property (
        $changed({INTERNAL_REFERENCE_EN, SEQUENCER_EN, SOFTWARE_MODE,
        SERIAL_INTERFACE, DUAL_LANE_EN, OVERSAMPLING, BURST_EN})
        |-> FULL_RESET_PULSE || $past(FULL_RESET_PULSE))
        else $error("latched strap moved");
    chk_range_live: assert property (
        !SOFTWARE_MODE && !$past(SOFTWARE_MODE) && !FULL_RESET_PULSE &&
        !$past(FULL_RESET_PULSE) && !SHUTDOWN && !$past(SHUTDOWN) |->
        INPUT_RANGE[1] == $past(RANGE_MODE_SELECT_HI) &&
        INPUT_RANGE[0] == $past(RANGE_MODE_SELECT_LO))
        else $error("range not tracking");
    chk_sw_range: assert property (
        SOFTWARE_MODE && !FULL_RESET_PULSE && !$past(FULL_RESET_PULSE)
        |-> INPUT_RANGE == 2'h0) else $error("range in software mode");
    chk_par_off: assert property (
        SERIAL_INTERFACE && $past(SERIAL_INTERFACE) |->
        &PARALLEL_DATA_OE_N) else $error("parallel driven in serial");
    chk_lane_b_off: assert property (
        !DUAL_LANE_EN && !$past(DUAL_LANE_EN) |-> SERIAL_OUT_LANE_B_OE_N)
        else $error("lane b driven");
endmodule
bind strap_config_latch strap_config_latch_properties i_chk (.*);

/* File: tb/strap_board_model.sv */
// Board strap wiring and host side of the data pins.
`timescale 1ns/1ps
`include "strap_config_defs.svh"
module strap_board_model (
    input wire logic [21:0] strap,
    input wire logic [`DATA_W-1:0] dut_data,
    input wire logic [`DATA_W-1:0] dut_oe_n,
    output logic ref_sel,
    output logic seq,
    output logic [1:0] rng,
    output logic ser,
    output logic burst,
    output logic [`DATA_W-1:0] wire_db
);
    logic [`DATA_W-1:0] tied;
    // ==========================================================
    // Straps
    assign ref_sel = strap[21];
    assign rng = strap[19:18];
    assign ser = strap[17];
    assign burst = strap[16];
    assign seq = strap[20] & (rng != 2'h0);
    always_comb begin
        tied = strap[15:0];
        if (rng == 2'h0) tied[5] = 1'b0;
        if (ser) tied[3:0] = 4'h0;
    end
    // The device wins wherever it drives, the strap level elsewhere.
    assign wire_db = (dut_oe_n & tied) | (~dut_oe_n & dut_data);
endmodule

/* File: tb/strap_config_latch_test.sv */
// Self-checking bench for the strap configuration latch.
`timescale 1ns/1ps
`include "strap_config_defs.svh"
module strap_config_latch_test;
    logic CORE_CLK = 1'b0, RST = 1'b1, RESET_PIN_N = 1'b1;
    logic CORE_PARALLEL_DRIVE = 1'b0, CORE_SERIAL_DRIVE = 1'b0;
    logic CORE_SERIAL_BIT_A = 1'b0, CORE_SERIAL_BIT_B = 1'b0;
    logic [15:0] CORE_PARALLEL_DATA = 16'h0000;
    logic [21:0] strap = '0, s;
    logic [11:0] cur;
    logic [12:0] exp_q[$];
    logic [12:0] want;
    logic kind;
    int n_errors = 0, samples_checked = 0;
    wire REFERENCE_SOURCE_SELECT, SEQUENCER_ENABLE_STRAP, BURST_STRAP;
    wire RANGE_MODE_SELECT_HI, RANGE_MODE_SELECT_LO, INTERFACE_TYPE_SELECT;
    wire [15:0] PARALLEL_DATA_IN, PARALLEL_DATA_OUT, PARALLEL_DATA_OE_N;
    logic CONFIG_VALID, INTERNAL_REFERENCE_EN, SEQUENCER_EN, SOFTWARE_MODE;
    logic SERIAL_INTERFACE, DUAL_LANE_EN, BURST_EN, SHUTDOWN;
    logic FULL_RESET_PULSE, PARTIAL_RESET_PULSE, SERIAL_OUT_LANE_A;
    logic SERIAL_OUT_LANE_A_OE_N, SERIAL_OUT_LANE_B, SERIAL_OUT_LANE_B_OE_N;
    logic [1:0] INPUT_RANGE;
    logic [2:0] OVERSAMPLING;
    wire [11:0] got_cfg = {CONFIG_VALID, INTERNAL_REFERENCE_EN,
        SEQUENCER_EN, SOFTWARE_MODE, SERIAL_INTERFACE,
        DUAL_LANE_EN & SERIAL_INTERFACE, OVERSAMPLING, BURST_EN, INPUT_RANGE};
    strap_config_latch i_dut (.*);
    strap_board_model i_board (.strap(strap), .dut_data(PARALLEL_DATA_OUT),
        .dut_oe_n(PARALLEL_DATA_OE_N), .ref_sel(REFERENCE_SOURCE_SELECT),
        .seq(SEQUENCER_ENABLE_STRAP), .ser(INTERFACE_TYPE_SELECT),
        .rng({RANGE_MODE_SELECT_HI, RANGE_MODE_SELECT_LO}),
        .burst(BURST_STRAP), .wire_db(PARALLEL_DATA_IN));
    always #5 CORE_CLK = ~CORE_CLK;
    // ==========================================================
    // Expected snapshot, in the bit order of got_cfg
    function automatic logic [11:0] expect_cfg(logic [21:0] v);
        logic sw;
        sw = (v[19:18] == 2'h0);
        return {1'b1, v[21], v[20] & !sw, sw, v[17], v[4] & v[17],
            (!sw && v[17]) ? v[15:13] : 3'h0, v[16] & !sw, v[19:18]};
    endfunction
    task automatic compare(logic [15:0] got, logic [15:0] want);
        samples_checked++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Pulls the reset pin low for n cycles with new straps on the board.
    task automatic pulse(int n, logic [21:0] v, logic note);
        strap = v;
        RESET_PIN_N = 1'b0;
        repeat (n) @(negedge CORE_CLK);
        compare({15'h0000, SHUTDOWN}, 16'h0001);
        RESET_PIN_N = 1'b1;
        if (note) exp_q.push_back({1'(n >= `FULL_RESET_CYCLES), cur});
        repeat (6) @(negedge CORE_CLK);
        compare({15'h0000, SHUTDOWN}, 16'h0000);
    endtask
    // ==========================================================
    // Monitor
    always @(negedge CORE_CLK) begin
        if (FULL_RESET_PULSE === 1'b1 || PARTIAL_RESET_PULSE === 1'b1) begin
            // The pulse kind rides in the top bit of each note.
            kind = FULL_RESET_PULSE;
            repeat (2) @(negedge CORE_CLK);
            if (exp_q.size() == 0)
                compare(16'h0001, 16'h0000);
            else begin
                want = exp_q.pop_front();
                compare({3'h0, kind, got_cfg}, {3'h0, want});
            end
        end
    end
    // ==========================================================
    // Stimulus
    initial begin
        #100_000;
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h3f14));
        repeat (12) @(negedge CORE_CLK);
        RST = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        for (int i = 0; i < 8; i++) begin
            s = 22'($urandom);
            s[19:18] = i[1:0];
            cur = expect_cfg(s);
            pulse(110, s, 1'b1);
            CORE_PARALLEL_DATA = 16'($urandom);
            CORE_SERIAL_BIT_A = CORE_PARALLEL_DATA[0];
            CORE_SERIAL_BIT_B = CORE_PARALLEL_DATA[1];
            CORE_PARALLEL_DRIVE = !s[17];
            CORE_SERIAL_DRIVE = s[17];
            repeat (3) @(negedge CORE_CLK);
            if (s[17])
                compare({12'h000, SERIAL_OUT_LANE_A_OE_N, SERIAL_OUT_LANE_A,
                    SERIAL_OUT_LANE_B_OE_N, SERIAL_OUT_LANE_B | !s[4]},
                    {12'h000, 1'b0, CORE_SERIAL_BIT_A, !s[4],
                    CORE_SERIAL_BIT_B | !s[4]});
            else
                compare(PARALLEL_DATA_IN, CORE_PARALLEL_DATA);
            CORE_PARALLEL_DRIVE = 1'b0;
            CORE_SERIAL_DRIVE = 1'b0;
            repeat (3) @(negedge CORE_CLK);
            compare(PARALLEL_DATA_OE_N, 16'hffff);
            pulse(2, s ^ 22'h33_ffff, 1'b0);
            pulse(20, s ^ 22'h33_ffff, 1'b1);
            for (int j = 1; j < 4 && i[1:0] != 2'h0; j++) begin
                strap[19:18] = j[1:0];
                repeat (3) @(negedge CORE_CLK);
                compare({14'h0000, INPUT_RANGE}, 16'(j));
            end
        end
        RST = 1'b1;
        repeat (2) @(negedge CORE_CLK);
        RST = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        compare({14'h0000, CONFIG_VALID, SOFTWARE_MODE}, 16'h0001);
        finish_test();
    end
endmodule
